// ---- dtc_pkg.sv ----
// Purpose: constants for the dual timer/counter block
// Assumes: 40 MHz pclk serves as the oscillator; one machine cycle is 12 pclk periods
// Notes: registers live on apb, one aligned 32-bit word each
package dtc_pkg;
   // register byte addresses
   localparam logic [11:0] DTC_OFF_CTRL = 12'h000;
   localparam logic [11:0] DTC_OFF_MODE = 12'h004;
   localparam logic [11:0] DTC_OFF_CNT0 = 12'h008;
   localparam logic [11:0] DTC_OFF_CNT1 = 12'h00c;
   localparam logic [11:0] DTC_OFF_VECT = 12'h010;
   // control register fields
   localparam int DTC_CTRL_OVF1 = 7;
   localparam int DTC_CTRL_RUN1 = 6;
   localparam int DTC_CTRL_OVF0 = 5;
   localparam int DTC_CTRL_RUN0 = 4;
   // mode register fields, per timer nibble
   localparam int DTC_MODE_GATE = 3;
   localparam int DTC_MODE_CT = 2;
   localparam int DTC_MODE_HI = 1;
   localparam int DTC_MODE_LO = 0;
   localparam int DTC_NIB1 = 4;
   // mode encodings
   localparam logic [1:0] DTC_M13 = 2'h0;
   localparam logic [1:0] DTC_M16 = 2'h1;
   localparam logic [1:0] DTC_M8R = 2'h2;
   localparam logic [1:0] DTC_MSPLIT = 2'h3;
   // machine cycle timing
   localparam int DTC_OSC_PER_MC = 12;
   localparam logic [3:0] DTC_MC_LAST = 4'hb;
   localparam logic [3:0] DTC_PH_SAMPLE = 4'h9;
   localparam logic [3:0] DTC_PH_UPDATE = 4'h4;
   // reset values
   localparam logic [7:0] DTC_RST_BYTE = 8'h00;
   localparam logic [1:0] DTC_RST_ENDS = 2'h0;
endpackage : dtc_pkg

// ---- dtc_top.sv ----
// Purpose: two 16-bit timer/counters with four modes, apb register access
// Assumes: pins are asynchronous to pclk; pclk is the oscillator
// Notes: overflow flags also clear on the interrupt-acknowledge register write
// Function
// - timer function counts once per machine cycle of 12 oscillator periods.
// - counter samples event pin at sample phase; counts high-then-low sample pairs.
// - counted edge becomes visible at update phase of the next machine cycle.
// - edge detection needs two machine cycles, so max rate is fosc/24.
// - per timer, function select picks timer/counter, two bits pick mode.
// - mode codes 00 13-bit, 01 16-bit, 10 auto-reload, 11 split/stop.
// - mode 0 uses high byte and low five bits as 13-bit counter.
// - 13-bit wrap from all ones sets the overflow flag.
// - count only when run set and gate clear or gate pin high.
// - setting run keeps existing count contents.
// - timer 1 gate at mode bit 7, timer 0 gate at mode bit 3.
// - mode 1 counts all 16 bits, sets flag on ffff wrap, continues.
// - software reads and writes overflow flags directly.
// - mode 2 low byte counts, reloads from high byte on overflow.
// - timer 1 in mode 3 holds its count, as if stopped.
// - timer 0 mode 3 splits: low byte own controls, high byte timer-1 controls.
// - with timer 0 split, timer 1 runs unless in its own mode 3.
// - overflow flag clears when its interrupt service is entered; here it clears only by a control write or an acknowledge register write.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module dtc_top
   import dtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic event_pin_t0,
   input wire logic event_pin_t1,
   input wire logic gate_pin_t0,
   input wire logic gate_pin_t1,
   output logic overflow_flag_t0,
   output logic overflow_flag_t1
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] count_low_t0_q;
   logic [7:0] count_high_t0_q;
   logic [7:0] count_low_t1_q;
   logic [7:0] count_high_t1_q;
   logic [7:0] counter_mode_register_q;
   logic run_bit_t0_q;
   logic run_bit_t1_q;
   logic ovf0_q;
   logic ovf1_q;
   logic [3:0] phase_q;
   logic [2:0] ev0_sync_q;
   logic [2:0] ev1_sync_q;
   logic [2:0] gt0_sync_q;
   logic [2:0] gt1_sync_q;
   logic ev0_lvl_q;
   logic ev1_lvl_q;
   logic gt0_lvl_q;
   logic gt1_lvl_q;
   logic ev0_smp_q;
   logic ev1_smp_q;
   logic ev0_pend_q;
   logic ev1_pend_q;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // a level is accepted once the second and third stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev0_sync_q <= 3'h0;
         ev1_sync_q <= 3'h0;
         gt0_sync_q <= 3'h0;
         gt1_sync_q <= 3'h0;
      end else begin
         ev0_sync_q <= {ev0_sync_q[1:0], event_pin_t0};
         ev1_sync_q <= {ev1_sync_q[1:0], event_pin_t1};
         gt0_sync_q <= {gt0_sync_q[1:0], gate_pin_t0};
         gt1_sync_q <= {gt1_sync_q[1:0], gate_pin_t1};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev0_lvl_q <= 1'b0;
         ev1_lvl_q <= 1'b0;
         gt0_lvl_q <= 1'b0;
         gt1_lvl_q <= 1'b0;
      end else begin
         if (ev0_sync_q[1] == ev0_sync_q[2]) ev0_lvl_q <= ev0_sync_q[2];
         if (ev1_sync_q[1] == ev1_sync_q[2]) ev1_lvl_q <= ev1_sync_q[2];
         if (gt0_sync_q[1] == gt0_sync_q[2]) gt0_lvl_q <= gt0_sync_q[2];
         if (gt1_sync_q[1] == gt1_sync_q[2]) gt1_lvl_q <= gt1_sync_q[2];
      end
   end

   // ----------------------------------------
   // machine cycle phase
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= 4'h0;
      end else if (phase_q == DTC_MC_LAST) begin
         phase_q <= 4'h0;
      end else begin
         phase_q <= phase_q + 4'h1;
      end
   end

   logic ph_sample;
   logic ph_update;
   assign ph_sample = (phase_q == DTC_PH_SAMPLE);
   assign ph_update = (phase_q == DTC_PH_UPDATE);

   // ----------------------------------------
   // event pin edge detection
   // ----------------------------------------
   // the edge seen at one sample phase is applied at the next cycle's update
   // phase, so two machine cycles bound the count rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev0_smp_q <= 1'b0;
         ev1_smp_q <= 1'b0;
         ev0_pend_q <= 1'b0;
         ev1_pend_q <= 1'b0;
      end else begin
         if (ph_sample) begin
            ev0_smp_q <= ev0_lvl_q;
            ev1_smp_q <= ev1_lvl_q;
            ev0_pend_q <= ev0_smp_q & ~ev0_lvl_q;
            ev1_pend_q <= ev1_smp_q & ~ev1_lvl_q;
         end else if (ph_update) begin
            ev0_pend_q <= 1'b0;
            ev1_pend_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // count enables
   // ----------------------------------------
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic ct0;
   logic ct1;
   logic gate0;
   logic gate1;
   logic split;
   logic tick0;
   logic tick1;
   logic tick0h;
   assign mode0 = counter_mode_register_q[DTC_MODE_HI:DTC_MODE_LO];
   assign mode1 = counter_mode_register_q[DTC_NIB1+DTC_MODE_HI:DTC_NIB1+DTC_MODE_LO];
   assign ct0 = counter_mode_register_q[DTC_MODE_CT];
   assign ct1 = counter_mode_register_q[DTC_NIB1+DTC_MODE_CT];
   assign gate0 = counter_mode_register_q[DTC_MODE_GATE];
   assign gate1 = counter_mode_register_q[DTC_NIB1+DTC_MODE_GATE];
   assign split = (mode0 == DTC_MSPLIT);
   // timer ticks land on the update phase too, so both functions align
   assign tick0 = ph_update & run_bit_t0_q & (~gate0 | gt0_lvl_q)
                  & (ct0 ? ev0_pend_q : 1'b1);
   // in split mode timer 1 runs freely on its own gate, without its run bit
   assign tick1 = ph_update & (split ? 1'b1 : run_bit_t1_q) & (~gate1 | gt1_lvl_q)
                  & (ct1 ? ev1_pend_q : 1'b1) & (mode1 != DTC_MSPLIT);
   assign tick0h = ph_update & run_bit_t1_q & split;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic wr_en;
   logic rd_en;
   logic hit;
   assign hit = (paddr == DTC_OFF_CTRL) | (paddr == DTC_OFF_MODE) | (paddr == DTC_OFF_CNT0)
              | (paddr == DTC_OFF_CNT1) | (paddr == DTC_OFF_VECT);
   assign wr_en = psel & penable & pwrite & hit;
   assign rd_en = psel & ~penable & ~pwrite;

   // ----------------------------------------
   // counter next values
   // ----------------------------------------
   logic [7:0] l0_d;
   logic [7:0] h0_d;
   logic [7:0] l1_d;
   logic [7:0] h1_d;
   logic set0;
   logic set1;

   // one function serves both timers; split-mode high byte handled separately
   function automatic logic [16:0] dtc_step(input logic [1:0] md, input logic [7:0] lo,
                                            input logic [7:0] hi);
      logic [8:0] s;
      logic [13:0] c13;
      logic [16:0] r;
      s = 9'h0;
      c13 = 14'h0;
      r = {1'b0, hi, lo};
      case (md)
         DTC_M13: begin
            c13 = {1'b0, hi, lo[4:0]} + 14'h1;
            r = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         end
         DTC_M16: begin
            r = {1'b0, hi, lo} + 17'h1;
         end
         DTC_M8R: begin
            s = {1'b0, lo} + 9'h1;
            r = {s[8], hi, (s[8] ? hi : s[7:0])};
         end
         default: begin // split low byte: plain 8-bit wrap
            s = {1'b0, lo} + 9'h1;
            r = {s[8], hi, s[7:0]};
         end
      endcase
      return r;
   endfunction : dtc_step

   always_comb begin
      logic [16:0] r0;
      logic [16:0] r1;
      logic [8:0] sh;
      r0 = dtc_step(mode0, count_low_t0_q, count_high_t0_q);
      r1 = dtc_step(mode1, count_low_t1_q, count_high_t1_q);
      sh = {1'b0, count_high_t0_q} + 9'h1;
      l0_d = count_low_t0_q;
      h0_d = count_high_t0_q;
      l1_d = count_low_t1_q;
      h1_d = count_high_t1_q;
      set0 = 1'b0;
      set1 = 1'b0;
      if (tick0) begin
         l0_d = r0[7:0];
         set0 = r0[16];
         if (!split) h0_d = r0[15:8];
      end
      if (tick0h) begin
         h0_d = sh[7:0];
         set1 = sh[8];
      end
      if (tick1) begin
         l1_d = r1[7:0];
         h1_d = r1[15:8];
         // in split mode timer 1 no longer owns its flag
         if (!split) set1 = r1[16];
      end
   end

   // ----------------------------------------
   // count registers
   // ----------------------------------------
   // software writes win over a same-cycle increment; run bits never clear counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_low_t0_q <= DTC_RST_BYTE;
         count_high_t0_q <= DTC_RST_BYTE;
         count_low_t1_q <= DTC_RST_BYTE;
         count_high_t1_q <= DTC_RST_BYTE;
      end else begin
         if (wr_en && paddr == DTC_OFF_CNT0) begin
            count_low_t0_q <= pwdata[7:0];
            count_high_t0_q <= pwdata[15:8];
         end else begin
            count_low_t0_q <= l0_d;
            count_high_t0_q <= h0_d;
         end
         if (wr_en && paddr == DTC_OFF_CNT1) begin
            count_low_t1_q <= pwdata[7:0];
            count_high_t1_q <= pwdata[15:8];
         end else begin
            count_low_t1_q <= l1_d;
            count_high_t1_q <= h1_d;
         end
      end
   end

   // ----------------------------------------
   // control, mode and flags
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_mode_register_q <= DTC_RST_BYTE;
         run_bit_t0_q <= 1'b0;
         run_bit_t1_q <= 1'b0;
      end else if (wr_en && paddr == DTC_OFF_MODE) begin
         counter_mode_register_q <= pwdata[7:0];
      end else if (wr_en && paddr == DTC_OFF_CTRL) begin
         run_bit_t0_q <= pwdata[DTC_CTRL_RUN0];
         run_bit_t1_q <= pwdata[DTC_CTRL_RUN1];
      end
   end

   // hardware set wins over a software or acknowledge clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf0_q <= 1'b0;
         ovf1_q <= 1'b0;
      end else begin
         if (set0) begin
            ovf0_q <= 1'b1;
         end else if (wr_en && paddr == DTC_OFF_CTRL) begin
            ovf0_q <= pwdata[DTC_CTRL_OVF0];
         end else if (wr_en && paddr == DTC_OFF_VECT && pwdata[0]) begin
            ovf0_q <= 1'b0;
         end
         if (set1) begin
            ovf1_q <= 1'b1;
         end else if (wr_en && paddr == DTC_OFF_CTRL) begin
            ovf1_q <= pwdata[DTC_CTRL_OVF1];
         end else if (wr_en && paddr == DTC_OFF_VECT && pwdata[1]) begin
            ovf1_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // apb response
   // ----------------------------------------
   // no wait state: read data is registered in setup, pready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         overflow_flag_t0 <= 1'b0;
         overflow_flag_t1 <= 1'b0;
      end else begin
         overflow_flag_t0 <= ovf0_q;
         overflow_flag_t1 <= ovf1_q;
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         if (rd_en) begin
            case (paddr)
               DTC_OFF_CTRL: prdata <= {24'h0, ovf1_q, run_bit_t1_q, ovf0_q, run_bit_t0_q, 4'h0};
               DTC_OFF_MODE: prdata <= {24'h0, counter_mode_register_q};
               DTC_OFF_CNT0: prdata <= {16'h0, count_high_t0_q, count_low_t0_q};
               DTC_OFF_CNT1: prdata <= {16'h0, count_high_t1_q, count_low_t1_q};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

endmodule : dtc_top
`default_nettype wire

// ---- dtc_assertions.sv ----
// Purpose: port-level checker for dtc_top
// Assumes: apb slave answers in the first access cycle, pready one cycle wide
// Notes: bound into dtc_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module dtc_assertions
   import dtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic event_pin_t0,
   input wire logic event_pin_t1,
   input wire logic gate_pin_t0,
   input wire logic gate_pin_t1,
   input wire logic overflow_flag_t0,
   input wire logic overflow_flag_t1
);
   logic setup;
   logic mapped;
   logic rd_done;
   assign setup = psel && !penable;
   assign mapped = paddr inside {DTC_OFF_CTRL, DTC_OFF_MODE, DTC_OFF_CNT0, DTC_OFF_CNT1,
      DTC_OFF_VECT};
   assign rd_done = psel && penable && pready && !pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (setup |=> pready && penable)
      else $error("no ready in access phase");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_error_unmapped: assert property (setup |=> pslverr == !mapped)
      else $error("error response does not match address");
   a_unmapped_zero: assert property (rd_done && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_ack_reads_zero: assert property (rd_done && paddr == DTC_OFF_VECT |-> prdata == 32'h0)
      else $error("acknowledge register read not zero");
   a_ctrl_flags: assert property (rd_done && paddr == DTC_OFF_CTRL |->
      prdata[DTC_CTRL_OVF0] == overflow_flag_t0 && prdata[DTC_CTRL_OVF1] == overflow_flag_t1)
      else $error("control read disagrees with flag outputs");
   a_flags_after_reset: assert property ($rose(presetn) |-> !overflow_flag_t0 && !overflow_flag_t1)
      else $error("flag high after reset");
   a_flag_no_clear: assert property ($fell(overflow_flag_t0) |->
      $past(psel && penable && pready && pwrite, 2))
      else $error("flag cleared without a write");
   c_unmapped: cover property (setup && !mapped);
   c_flag0: cover property ($rose(overflow_flag_t0));
   c_flag1: cover property ($rose(overflow_flag_t1));
endmodule : dtc_assertions
bind dtc_top dtc_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .event_pin_t0(event_pin_t0),
   .event_pin_t1(event_pin_t1), .gate_pin_t0(gate_pin_t0), .gate_pin_t1(gate_pin_t1),
   .overflow_flag_t0(overflow_flag_t0), .overflow_flag_t1(overflow_flag_t1));
`default_nettype wire

// ---- dtc_pins_model.sv ----
// Purpose: external event sources and gate drivers for both timers
// Assumes: pins idle high for events, low for gates
// Notes: each level is held one machine cycle, the fastest legal rate
`timescale 1ns/1ps
`default_nettype none
module dtc_pins_model (
   input wire logic pclk,
   output logic event_pin_t0,
   output logic event_pin_t1,
   output logic gate_pin_t0,
   output logic gate_pin_t1
);
   initial begin
      event_pin_t0 = 1'b1;
      event_pin_t1 = 1'b1;
      gate_pin_t0 = 1'b0;
      gate_pin_t1 = 1'b0;
   end
   task automatic pulses(input int tmr, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge pclk);
         if (tmr == 0) event_pin_t0 <= i[0];
         else event_pin_t1 <= i[0];
         repeat (11) @(posedge pclk);
      end
   endtask : pulses
   task automatic set_gate(input int tmr, input logic v);
      @(posedge pclk);
      if (tmr == 0) gate_pin_t0 <= v;
      else gate_pin_t1 <= v;
   endtask : set_gate
endmodule : dtc_pins_model
`default_nettype wire

// ---- dtc_top_tb.sv ----
// Purpose: self-checking bench for dtc_top
// Assumes: one wait-free apb access per transfer
// Notes: count spans are multiples of a machine cycle so counts are exact
`timescale 1ns/1ps
`default_nettype none
module dtc_top_tb;
   import dtc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic overflow_flag_t0;
   logic overflow_flag_t1;
   wire event_pin_t0;
   wire event_pin_t1;
   wire gate_pin_t0;
   wire gate_pin_t1;
   logic [32:0] exp_q[$];
   logic [7:0] rnd;
   int failures = 0;
   int checks_done = 0;
   int n;
   initial forever #12.5 pclk = ~pclk;
   dtc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_pin_t0(event_pin_t0), .event_pin_t1(event_pin_t1),
      .gate_pin_t0(gate_pin_t0), .gate_pin_t1(gate_pin_t1),
      .overflow_flag_t0(overflow_flag_t0), .overflow_flag_t1(overflow_flag_t1));
   dtc_pins_model u_pins (.pclk(pclk), .event_pin_t0(event_pin_t0),
      .event_pin_t1(event_pin_t1), .gate_pin_t0(gate_pin_t0), .gate_pin_t1(gate_pin_t1));
   task automatic conclude;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic compare(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         failures++;
         conclude();
      end
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // reads are judged here against the oldest expectation
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         compare({pslverr, prdata}, exp_q.pop_front());
      end
   end
   // run for exactly k machine cycles, checking flags while running
   task automatic run(input logic [11:0] ca, input logic [15:0] cv, input logic [7:0] md,
      input logic [7:0] go, input int k, input logic [7:0] fl);
      apb(1'b1, ca, {16'h0, cv});
      apb(1'b1, DTC_OFF_MODE, {24'h0, md});
      apb(1'b1, DTC_OFF_CTRL, {24'h0, go});
      repeat (12 * k - 6) @(posedge pclk);
      rd(DTC_OFF_CTRL, {25'h0, go | fl});
      apb(1'b1, DTC_OFF_CTRL, {24'h0, fl});
   endtask : run
   initial begin
      void'($urandom(57));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(DTC_OFF_CTRL, 33'h0);
      rd(DTC_OFF_MODE, 33'h0);
      rd(DTC_OFF_CNT0, 33'h0);
      rd(DTC_OFF_CNT1, 33'h0);
      apb(1'b1, 12'h020, 32'hffff_ffff);
      rd(12'h020, {1'b1, 32'h0});
      rd(DTC_OFF_VECT, 33'h0);
      rnd = 8'($urandom);
      apb(1'b1, DTC_OFF_MODE, {24'h0, rnd});
      rd(DTC_OFF_MODE, {25'h0, rnd});
      $display("test reset and access done");
      run(DTC_OFF_CNT0, 16'hfff0, 8'h01, 8'h10, 20, 8'h20);
      rd(DTC_OFF_CNT0, 33'h4);
      run(DTC_OFF_CNT1, 16'hff1f, 8'h00, 8'h40, 2, 8'h80);
      rd(DTC_OFF_CNT1, 33'h1);
      run(DTC_OFF_CNT0, 16'h80fe, 8'h02, 8'h10, 3, 8'h20);
      rd(DTC_OFF_CNT0, 33'h8081);
      $display("test modes 0 1 2 done");
      run(DTC_OFF_CNT1, 16'h1234, 8'h30, 8'h40, 2, 8'h00);
      rd(DTC_OFF_CNT1, 33'h1234);
      run(DTC_OFF_CNT0, 16'hfffe, 8'h33, 8'h50, 3, 8'ha0);
      rd(DTC_OFF_CNT0, 33'h0201);
      rd(DTC_OFF_CNT1, 33'h1234);
      apb(1'b1, DTC_OFF_MODE, 32'h13);
      repeat (21) @(posedge pclk);
      apb(1'b1, DTC_OFF_MODE, 32'h33);
      rd(DTC_OFF_CNT1, 33'h1236);
      $display("test split mode done");
      compare({31'h0, overflow_flag_t1, overflow_flag_t0}, 33'h3);
      apb(1'b1, DTC_OFF_VECT, 32'h1);
      rd(DTC_OFF_CTRL, 33'h80);
      apb(1'b1, DTC_OFF_VECT, 32'h2);
      rd(DTC_OFF_CTRL, 33'h0);
      apb(1'b1, DTC_OFF_CTRL, 32'h20);
      rd(DTC_OFF_CTRL, 33'h20);
      $display("test flags done");
      apb(1'b1, DTC_OFF_MODE, 32'hdd);
      apb(1'b1, DTC_OFF_CTRL, 32'h50);
      for (int t = 0; t < 2; t++) begin
         apb(1'b1, t ? DTC_OFF_CNT1 : DTC_OFF_CNT0, 32'h0);
         u_pins.pulses(t, 3);
         repeat (36) @(posedge pclk);
         u_pins.set_gate(t, 1'b1);
         repeat (12) @(posedge pclk);
         n = 1 + $urandom % 8;
         u_pins.pulses(t, n);
         repeat (48) @(posedge pclk);
         rd(t ? DTC_OFF_CNT1 : DTC_OFF_CNT0, 33'(n));
      end
      $display("test counter and gate done");
      // reset in mid-run with runs, flags, modes and counts all non-zero
      apb(1'b1, DTC_OFF_CTRL, 32'hf0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(DTC_OFF_CTRL, 33'h0);
      rd(DTC_OFF_MODE, 33'h0);
      rd(DTC_OFF_CNT0, 33'h0);
      rd(DTC_OFF_CNT1, 33'h0);
      $display("test mid-run reset done");
      conclude();
   end
endmodule : dtc_top_tb
`default_nettype wire
